// ==== logic/iomap_regs.svh ====
`ifndef IOMAP_REGS_SVH
`define IOMAP_REGS_SVH

// Object indices, primary and alternative
`define IOM_IDX_DIN 16'h6000
`define IOM_IDX_DIN_ALT 16'h2000
`define IOM_IDX_DOUT 16'h6200
`define IOM_IDX_DOUT_ALT 16'h2100
`define IOM_IDX_AIN 16'h6401
`define IOM_IDX_AIN_ALT 16'h2400
`define IOM_IDX_AOUT 16'h6411
`define IOM_IDX_AOUT_ALT 16'h2500
// Raw image byte views, event status and mask
`define IOM_IDX_IN_IMG 16'h3f00
`define IOM_IDX_OUT_IMG 16'h3f01
`define IOM_IDX_EV_STAT 16'h3f10
`define IOM_IDX_EV_MASK 16'h3f11

// First subindex of each digital and analog object
`define IOM_SUB_BASE 8'h01

// Event bit positions and event field width
`define IOM_EV_FAULT 0
`define IOM_EV_EMCY 1
`define IOM_EV_BADACC 2
`define IOM_EV_W 3

// Reset values
`define IOM_DOUT_RST 8'h00
`define IOM_AOUT_RST 16'h0000
`define IOM_MASK_RST 3'h0

`endif

// ==== logic/iomap_pkg.sv ====
package iomap_pkg;

  typedef struct packed {
    logic [15:0] index;
    logic [7:0] sub;
  } obj_addr_s;

  typedef struct packed {
    logic [7:0] channel;
    logic [7:0] status;
  } emcy_s;

endpackage

// ==== logic/io_process_image_mapper.sv ====
// Operation
// RL1: Each switched output channel has its own fault flag, channel 1 at bit 0.
// RL2: Fault flag zero means healthy, one means overload, short or open load.
// RL3: Output image bit k drives switched output channel k+1.
// RL4: Fault byte is read under the digital input index or its alternative.
// RL5: Switched output byte is written under the digital output index or its alternative.
// RL6: Analog inputs pass only the 16-bit value; the status byte is withheld.
// RL7: Analog input words sit in the image low byte first.
// RL8: Analog input words precede digital input bytes in the input image.
// RL9: Analog input channel k is subindex n+k-1 at byte offset 2(k-1).
// RL10: A one-channel input module gives measurement then reference on two subindices.
// RL11: Analog outputs take only a 16-bit value; no control byte is writable.
// RL12: Analog output status byte goes out as an emergency message.
// RL13: Analog output words are taken from the image low byte first.
// RL14: Analog output words precede digital output bytes in the output image.
// RL15: Analog output channel k is its own subindex of the output object or alternative.
// RL16: Outputs hold their last written value until a new write arrives.
//
// Added by the designer: the strobed register port and the placing of the registers.
`include "iomap_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module io_process_image_mapper
  import iomap_pkg::*;
#(
  parameter int AI_CH = 4,
  parameter int AO_CH = 4
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire obj_addr_s addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [7:0] fault_i,
  output logic [7:0] dout_o,
  input wire logic [AI_CH-1:0][15:0] ain_i,
  input wire logic [AO_CH-1:0][7:0] aout_stat_i,
  output logic [AO_CH-1:0][15:0] aout_o,
  output logic emcy_valid_o,
  output emcy_s emcy_o,
  output logic irq_o
);

  // ****************************************************************
  // Object decode
  // ****************************************************************
  localparam logic [7:0] AI_BYTES = 8'(2 * AI_CH);
  localparam logic [7:0] AO_BYTES = 8'(2 * AO_CH);

  function automatic logic sub_in(input logic [7:0] sub, input logic [7:0] cnt);
    sub_in = (sub >= `IOM_SUB_BASE) && ((sub - `IOM_SUB_BASE) < cnt);
  endfunction

  wire logic [7:0] sub_idx_w = addr_i.sub - `IOM_SUB_BASE;
  wire logic din_hit_w = ((addr_i.index == `IOM_IDX_DIN) ||
                          (addr_i.index == `IOM_IDX_DIN_ALT)) &&
                         (addr_i.sub == `IOM_SUB_BASE); // RL4
  wire logic dout_hit_w = ((addr_i.index == `IOM_IDX_DOUT) ||
                           (addr_i.index == `IOM_IDX_DOUT_ALT)) &&
                          (addr_i.sub == `IOM_SUB_BASE); // RL5
  wire logic ain_hit_w = ((addr_i.index == `IOM_IDX_AIN) ||
                          (addr_i.index == `IOM_IDX_AIN_ALT)) &&
                         sub_in(addr_i.sub, 8'(AI_CH)); // RL9 RL10
  wire logic aout_hit_w = ((addr_i.index == `IOM_IDX_AOUT) ||
                           (addr_i.index == `IOM_IDX_AOUT_ALT)) &&
                          sub_in(addr_i.sub, 8'(AO_CH)); // RL15
  wire logic inimg_hit_w = (addr_i.index == `IOM_IDX_IN_IMG) && (addr_i.sub <= AI_BYTES);
  wire logic outimg_hit_w = (addr_i.index == `IOM_IDX_OUT_IMG) && (addr_i.sub <= AO_BYTES);
  wire logic stat_hit_w = (addr_i.index == `IOM_IDX_EV_STAT) && (addr_i.sub == 8'h00);
  wire logic mask_hit_w = (addr_i.index == `IOM_IDX_EV_MASK) && (addr_i.sub == 8'h00);

  // Only the output objects, raw output image and mask take writes
  wire logic wr_ok_w = dout_hit_w || aout_hit_w || outimg_hit_w || mask_hit_w; // RL11
  wire logic rd_ok_w = din_hit_w || dout_hit_w || ain_hit_w || aout_hit_w ||
                       inimg_hit_w || outimg_hit_w || stat_hit_w || mask_hit_w;
  wire logic bad_acc_w = (wr_i && !wr_ok_w) || (rd_i && !rd_ok_w);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [7:0] fault_s1_q;
  logic [7:0] fault_s2_q;
  logic [7:0] fault_prev_q;
  logic [AI_CH-1:0][15:0] ain_s1_q;
  logic [AI_CH-1:0][15:0] ain_s2_q;
  logic [AO_CH-1:0][7:0] stat_s1_q;
  logic [AO_CH-1:0][7:0] stat_s2_q;

  // Only the value word of each analog input is brought in
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fault_s1_q <= 8'h00;
      fault_s2_q <= 8'h00;
      fault_prev_q <= 8'h00;
      ain_s1_q <= '0;
      ain_s2_q <= '0; // RL6
      stat_s1_q <= '0;
      stat_s2_q <= '0;
    end
    else
    begin
      fault_s1_q <= fault_i;
      fault_s2_q <= fault_s1_q; // RL1
      fault_prev_q <= fault_s2_q;
      ain_s1_q <= ain_i;
      ain_s2_q <= ain_s1_q; // RL6
      stat_s1_q <= aout_stat_i;
      stat_s2_q <= stat_s1_q;
    end
  end

  // ****************************************************************
  // Output image
  // ****************************************************************
  logic [7:0] dout_q;
  logic [AO_CH-1:0][15:0] aout_q;

  // Digital byte sits right after the analog words in the raw output image
  wire logic dout_we_w = wr_i && (dout_hit_w || (outimg_hit_w && addr_i.sub == AO_BYTES)); // RL14

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dout_q <= `IOM_DOUT_RST;
    else if (dout_we_w)
      dout_q <= wdata_i[7:0]; // RL3
  end

  genvar g;
  generate
    for (g = 0; g < AO_CH; g++)
    begin : g_aout
      wire logic word_we_w = wr_i && aout_hit_w && (sub_idx_w == 8'(g)); // RL15
      wire logic byte_we_w = wr_i && outimg_hit_w && (addr_i.sub[7:1] == 7'(g)) &&
                             (addr_i.sub < AO_BYTES);
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          aout_q[g] <= `IOM_AOUT_RST;
        else if (word_we_w)
          aout_q[g] <= wdata_i; // RL11
        else if (byte_we_w && !addr_i.sub[0])
          aout_q[g][7:0] <= wdata_i[7:0]; // RL13
        else if (byte_we_w)
          aout_q[g][15:8] <= wdata_i[7:0]; // RL13
      end // RL16
    end
  endgenerate

  // ****************************************************************
  // Emergency reporting of analog output status
  // ****************************************************************
  logic [AO_CH-1:0][7:0] stat_rep_q;
  logic emcy_hit;
  logic [7:0] emcy_ch;

  // Lowest channel whose status differs from what was last reported
  always_comb
  begin
    emcy_hit = 1'b0;
    emcy_ch = 8'h00;
    for (int i = 0; i < AO_CH; i++)
    begin
      if (!emcy_hit && (stat_s2_q[i] != stat_rep_q[i]))
      begin
        emcy_hit = 1'b1;
        emcy_ch = 8'(i);
      end
    end
  end

  generate
    for (g = 0; g < AO_CH; g++)
    begin : g_stat
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          stat_rep_q[g] <= 8'h00;
        else if (emcy_hit && (emcy_ch == 8'(g)))
          stat_rep_q[g] <= stat_s2_q[g]; // RL12
      end
    end
  endgenerate

  wire emcy_s emcy_w = '{channel: emcy_ch, status: stat_s2_q[emcy_ch]};

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      emcy_valid_o <= 1'b0;
      emcy_o <= '0;
    end
    else
    begin
      emcy_valid_o <= emcy_hit; // RL12
      emcy_o <= emcy_hit ? emcy_w : emcy_o;
    end
  end

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  logic [`IOM_EV_W-1:0] ev_stat_q;
  logic [`IOM_EV_W-1:0] ev_mask_q;

  wire logic fault_rise_w = |(fault_s2_q & ~fault_prev_q); // RL2
  wire logic [`IOM_EV_W-1:0] ev_set_w = {bad_acc_w, emcy_hit, fault_rise_w};
  wire logic ev_clr_w = rd_i && stat_hit_w;
  // A new event in the clearing cycle survives
  wire logic [`IOM_EV_W-1:0] ev_stat_d = (ev_clr_w ? '0 : ev_stat_q) | ev_set_w;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ev_stat_q <= '0;
      ev_mask_q <= `IOM_MASK_RST;
      irq_o <= 1'b0;
    end
    else
    begin
      ev_stat_q <= ev_stat_d;
      if (wr_i && mask_hit_w)
        ev_mask_q <= wdata_i[`IOM_EV_W-1:0];
      irq_o <= |(ev_stat_q & ev_mask_q);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Analog words first, then the digital byte; low byte at even offset
  wire logic [15:0] in_word_w = ain_s2_q[addr_i.sub[7:1]];
  wire logic [15:0] out_word_w = aout_q[addr_i.sub[7:1]];
  wire logic [7:0] in_byte_w = (addr_i.sub == AI_BYTES) ? fault_s2_q : // RL8
                               (addr_i.sub[0] ? in_word_w[15:8] : in_word_w[7:0]); // RL7
  wire logic [7:0] out_byte_w = (addr_i.sub == AO_BYTES) ? dout_q :
                                (addr_i.sub[0] ? out_word_w[15:8] : out_word_w[7:0]);
  wire logic [15:0] rd_mux_w =
    din_hit_w ? {8'h00, fault_s2_q} : // RL1
    dout_hit_w ? {8'h00, dout_q} :
    ain_hit_w ? ain_s2_q[sub_idx_w] : // RL9
    aout_hit_w ? aout_q[sub_idx_w] :
    inimg_hit_w ? {8'h00, in_byte_w} :
    outimg_hit_w ? {8'h00, out_byte_w} :
    stat_hit_w ? 16'(ev_stat_q) :
    mask_hit_w ? 16'(ev_mask_q) : 16'h0000;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 16'h0000;
    else
      rdata_o <= rd_i ? rd_mux_w : 16'h0000;
  end

  assign dout_o = dout_q;
  assign aout_o = aout_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_FAULT_READ: assert property (rd_i && din_hit_w |=> rdata_o == {8'h00, $past(fault_s2_q)}) // RL1
    else $error("fault byte read mismatch");
  AST_FAULT_EVENT: assert property ((fault_s2_q & ~fault_prev_q) != 8'h00 |=> ev_stat_q[0]) // RL2
    else $error("fault rise not flagged");
  AST_DOUT_WRITE: assert property (wr_i && dout_hit_w |=> dout_o == $past(wdata_i[7:0])) // RL3
    else $error("switched output not applied");
  AST_DIN_ALT: assert property (rd_i && addr_i.index == `IOM_IDX_DIN_ALT && // RL4
                                addr_i.sub == `IOM_SUB_BASE |->
                                !bad_acc_w ##1 (rdata_o == {8'h00, $past(fault_s2_q)}))
    else $error("alternative input index refused");
  AST_DOUT_ALT: assert property (wr_i && addr_i.index == `IOM_IDX_DOUT_ALT && // RL5
                                 addr_i.sub == `IOM_SUB_BASE |=> dout_o == $past(wdata_i[7:0]))
    else $error("alternative output index refused");
  AST_AIN_FIRST: assert property (rd_i && addr_i.index == `IOM_IDX_AIN && // RL9
                                  addr_i.sub == `IOM_SUB_BASE |=> rdata_o == $past(ain_i[0], 3))
    else $error("first analog input word mismatch");
  AST_IMG_LSB: assert property (rd_i && addr_i.index == `IOM_IDX_IN_IMG && // RL7
                                addr_i.sub == 8'h00 |=>
                                rdata_o == {8'h00, $past(ain_s2_q[0][7:0])})
    else $error("input image low byte mismatch");
  AST_IMG_ORDER: assert property (rd_i && addr_i.index == `IOM_IDX_IN_IMG && // RL8
                                  addr_i.sub == AI_BYTES |=> rdata_o == {8'h00, $past(fault_s2_q)})
    else $error("digital byte not after analog words");
  AST_CTRL_LOCKED: assert property (wr_i && (addr_i.index == `IOM_IDX_AOUT) && // RL11
                                    !sub_in(addr_i.sub, 8'(AO_CH)) |=> $stable(aout_o))
    else $error("write outside analog words changed an output");
  AST_EMCY: assert property ($changed(stat_s2_q) |-> ##[0:12] emcy_valid_o) // RL12
    else $error("status change not reported");
  AST_AOUT_BYTE: assert property (wr_i && addr_i.index == `IOM_IDX_OUT_IMG && // RL13
                                  addr_i.sub == 8'h01 |=> aout_o[0][15:8] == $past(wdata_i[7:0]))
    else $error("output image high byte mismatch");
  AST_OUT_ORDER: assert property (wr_i && addr_i.index == `IOM_IDX_OUT_IMG && // RL14
                                  addr_i.sub == AO_BYTES |=> dout_o == $past(wdata_i[7:0]))
    else $error("digital output byte misplaced");
  AST_AOUT_WORD: assert property (wr_i && addr_i.index == `IOM_IDX_AOUT_ALT && // RL15
                                  addr_i.sub == `IOM_SUB_BASE |=> aout_o[0] == $past(wdata_i))
    else $error("analog output word not applied");
  AST_HOLD: assert property (!wr_i |=> $stable(dout_o) && $stable(aout_o)) // RL16
    else $error("output changed without a write");

  // Input image: high bytes, last channel and healthy flags
  AST_AIN_HI: assert property ( // RL7
    rd_i && addr_i.index == `IOM_IDX_IN_IMG && addr_i.sub == 8'h01 |=>
    rdata_o == {8'h00, $past(ain_s2_q[0][15:8])})
    else $error("input image high byte mismatch");
  AST_AIN_LAST: assert property ( // RL9
    rd_i && ain_hit_w && addr_i.sub == 8'(AI_CH) |=>
    rdata_o == $past(ain_s2_q[AI_CH-1]))
    else $error("last analog input word mismatch");
  AST_FAULT_HEALTHY: assert property ( // RL2
    rd_i && din_hit_w && fault_s2_q == 8'h00 |=>
    rdata_o == 16'h0000)
    else $error("healthy channels read as faulty");

  // Output image: word and byte writes, digital byte kept apart
  AST_AOUT_LAST: assert property ( // RL15
    wr_i && addr_i.index == `IOM_IDX_AOUT && addr_i.sub == 8'(AO_CH) |=>
    aout_o[AO_CH-1] == $past(wdata_i))
    else $error("last analog output word not applied");
  AST_AOUT_LOW: assert property ( // RL13
    wr_i && outimg_hit_w && addr_i.sub < AO_BYTES && !addr_i.sub[0] |=>
    aout_o[$past(addr_i.sub[7:1])][7:0] == $past(wdata_i[7:0]))
    else $error("output image low byte mismatch");
  AST_AOUT_KEEP_LO: assert property ( // RL13
    wr_i && outimg_hit_w && addr_i.sub < AO_BYTES && addr_i.sub[0] |=>
    aout_o[$past(addr_i.sub[7:1])][7:0] == $past(aout_o[addr_i.sub[7:1]][7:0]))
    else $error("high byte write disturbed low byte");
  AST_DOUT_KEEP: assert property ( // RL14
    wr_i && outimg_hit_w && addr_i.sub < AO_BYTES |=>
    $stable(dout_o))
    else $error("analog byte write changed digital byte");

  COV_FAULT: cover property (fault_rise_w ##1 irq_o);
  COV_EMCY: cover property (emcy_valid_o && emcy_o.status != 8'h00);
  COV_AOUT: cover property (wr_i && aout_hit_w ##1 rd_i && aout_hit_w);
  COV_CLR: cover property (ev_clr_w && ev_set_w != '0);
  COV_BADACC: cover property (bad_acc_w ##1 ev_stat_q[`IOM_EV_BADACC]);

endmodule

`default_nettype wire

// ==== verif/can_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module can_master_model
  import iomap_pkg::*;
(
  input wire logic clk_i,
  output var obj_addr_s addr_o,
  output var logic [15:0] wdata_o,
  output var logic wr_o,
  output var logic rd_o,
  input wire logic [15:0] rdata_i
);
  // ****************************************
  // Process data requests
  // ****************************************
  initial
  begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Sends a 16-bit value to any index and subindex, including the event mask and subindex 0
  task automatic wr_obj(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] v);
    @(posedge clk_i);
    addr_o <= {idx, sub};
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~{idx, sub};
    wdata_o <= ~v;
  endtask

  // Released lines show the inverse so stale values cannot pass
  task automatic rd_obj(input logic [15:0] idx, input logic [7:0] sub, output logic [15:0] v);
    @(posedge clk_i);
    addr_o <= {idx, sub};
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~{idx, sub};
    #1;
    v = rdata_i;
  endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "iomap_regs.svh"
module testbench
  import iomap_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  localparam int AI_N = 4;
  localparam int AO_N = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  obj_addr_s addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [7:0] fault = 8'h00;
  logic [7:0] dout;
  logic [AI_N-1:0][15:0] ain = '0;
  logic [AO_N-1:0][7:0] astat = '0;
  logic [AO_N-1:0][15:0] aout;
  logic emcy_valid;
  emcy_s emcy;
  logic irq;
  logic [15:0] d;
  logic [15:0] v;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  io_process_image_mapper #(.AI_CH(AI_N), .AO_CH(AO_N)) i_dut (
    .clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .fault_i(fault), .dout_o(dout), .ain_i(ain),
    .aout_stat_i(astat), .aout_o(aout), .emcy_valid_o(emcy_valid), .emcy_o(emcy),
    .irq_o(irq));
  can_master_model i_master (
    .clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Checks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] wval(input logic [15:0] seed, input int k);
    return seed ^ (16'h1111 * 16'(k + 1));
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_dout();
    for (int k = 0; k < 8; k++)
    begin
      i_master.wr_obj((k % 2) ? `IOM_IDX_DOUT_ALT : `IOM_IDX_DOUT, 8'h01, 16'h0001 << k);
      #1;
      chk("dout", {8'h00, dout}, 16'h0001 << k);
      i_master.rd_obj(`IOM_IDX_EV_MASK, 8'h00, d);
      chk("dout_hold", {8'h00, dout}, 16'h0001 << k);
    end
    i_master.wr_obj(`IOM_IDX_OUT_IMG, 8'(2 * AO_N), 16'h003c);
    #1;
    chk("dout_raw", {8'h00, dout}, 16'h003c);
  endtask

  task automatic t_fault();
    for (int k = 0; k <= 8; k++)
    begin
      @(posedge clk);
      fault <= (k < 8) ? 8'h01 << k : 8'h00;
      idle(4);
      v = (k < 8) ? 16'h0001 << k : 16'h0000;
      i_master.rd_obj(`IOM_IDX_DIN, 8'h01, d);
      chk("din", d, v);
      i_master.rd_obj(`IOM_IDX_DIN_ALT, 8'h01, d);
      chk("din_alt", d, v);
      i_master.rd_obj(`IOM_IDX_IN_IMG, 8'(2 * AI_N), d);
      chk("din_raw", d, v);
    end
  endtask

  task automatic t_ain();
    @(posedge clk);
    for (int k = 0; k < AI_N; k++)
      ain[k] <= wval(16'hc35a, k);
    idle(4);
    for (int k = 0; k < AI_N; k++)
    begin
      v = wval(16'hc35a, k);
      i_master.rd_obj((k % 2) ? `IOM_IDX_AIN_ALT : `IOM_IDX_AIN, 8'(1 + k), d);
      chk("ain", d, v);
      i_master.rd_obj(`IOM_IDX_IN_IMG, 8'(2 * k), d);
      chk("ain_lo", d, {8'h00, v[7:0]});
      i_master.rd_obj(`IOM_IDX_IN_IMG, 8'(2 * k + 1), d);
      chk("ain_hi", d, {8'h00, v[15:8]});
    end
  endtask

  task automatic t_aout();
    for (int k = 0; k < AO_N; k++)
    begin
      i_master.wr_obj((k % 2) ? `IOM_IDX_AOUT : `IOM_IDX_AOUT_ALT, 8'(1 + k), wval(16'h0f1e, k));
      #1;
      chk("aout", aout[k], wval(16'h0f1e, k));
    end
    v = wval(16'h0f1e, 1);
    i_master.wr_obj(`IOM_IDX_OUT_IMG, 8'h02, 16'h007e);
    #1;
    chk("aout_lo", aout[1], {v[15:8], 8'h7e});
    i_master.wr_obj(`IOM_IDX_OUT_IMG, 8'h03, 16'h0081);
    #1;
    chk("aout_hi", aout[1], 16'h817e);
    chk("dout_keep", {8'h00, dout}, 16'h003c);
    v = wval(16'h0f1e, 0);
    i_master.wr_obj(`IOM_IDX_OUT_IMG, 8'h01, 16'h00c3);
    #1;
    chk("aout_b1", aout[0], {8'hc3, v[7:0]});
    i_master.wr_obj(`IOM_IDX_AOUT, 8'h00, 16'hffff);
    #1;
    chk("aout_ctrl", aout[0], {8'hc3, v[7:0]});
  endtask

  task automatic t_emcy();
    @(posedge clk);
    astat[2] <= 8'h5a;
    d = 16'h0000;
    repeat (10)
    begin
      @(posedge clk);
      #1;
      if (emcy_valid === 1'b1)
        d = d + 16'h0001;
    end
    chk("emcy_pulses", d, 16'h0001);
    chk("emcy_stat", {8'h00, emcy.status}, 16'h005a);
    chk("emcy_ch", {8'h00, emcy.channel}, 16'h0002);
  endtask

  task automatic t_irq();
    i_master.rd_obj(`IOM_IDX_EV_STAT, 8'h00, d);
    i_master.rd_obj(16'h1234, 8'h00, d);
    chk("unmapped", d, 16'h0000);
    idle(2);
    chk("irq_masked", {15'h0000, irq}, 16'h0000);
    i_master.wr_obj(`IOM_IDX_EV_MASK, 8'h00, 16'h0004);
    idle(2);
    chk("irq_on", {15'h0000, irq}, 16'h0001);
    i_master.rd_obj(`IOM_IDX_EV_STAT, 8'h00, d);
    chk("ev_stat", d, 16'h0004);
    idle(2);
    chk("irq_off", {15'h0000, irq}, 16'h0000);
  endtask

  // ****************************************
  // Main
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    idle(2);
    chk("dout_rst", {8'h00, dout}, {8'h00, `IOM_DOUT_RST});
    t_dout();
    t_fault();
    t_ain();
    t_aout();
    t_emcy();
    t_irq();
    close_out();
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      close_out();
    end
  end
endmodule
`default_nettype wire
